// [common/cache_tlb_pkg.sv]
// Purpose: Shared constants for the cache and TLB boot block
// Assumes: 40-bit physical addresses, 64-bit virtual addresses
// Notes: Index widths size the arrays in the design
package cache_tlb_pkg;
	// ****************************************
	// Streaming cache tag RAM
	// ****************************************
	localparam int SETS = 4;
	localparam int TI_W = 4;
	localparam int TI_LO = 7;
	localparam int TAG_LO_W = 20;
	localparam int TAG_W = 22;
	localparam int SECT = 4;
	localparam int SECT_W = 3;
	localparam int WEN_LO = 12;
	localparam int ACC_HI = 21;
	localparam int ACC_LO = 20;
	// ****************************************
	// Tag space decode for loads
	// ****************************************
	localparam logic [15:0] TAG_SPACE_PAGE = 16'h0018;
	localparam int TS_PAGE_LO = 24;
	localparam int TS_STATE_BIT = 23;
	localparam int TS_SET_LO = 21;
	// ****************************************
	// TLB
	// ****************************************
	localparam int TLB_SETS = 3;
	localparam int TLB_IDX_W = 4;
	localparam int VPN_W = 20;
	localparam int LO_W = 32;
	localparam int LO_VALID = 0;
	// ****************************************
	// On-chip caches, 16 KByte each, 32-byte lines
	// ****************************************
	localparam int PA_W = 40;
	localparam int LINE_IDX_W = 9;
	localparam int LINE_LO = 5;
	localparam int CTAG_LO = 14;
	localparam int CTAG_W = PA_W - CTAG_LO;
	localparam int HALF_IDX_W = 10;
	localparam int HALF_LO = 4;
	localparam int WORD_LO = 2;
	localparam int WORDS = 4;
	// ****************************************
	// Uncached fetch attribute in vaddr 63:59
	// ****************************************
	localparam int ATTR_LO = 59;
	localparam logic [4:0] ATTR_GATHER = 5'h10;
	localparam logic [4:0] ATTR_UNC_SEQ = 5'h12;
	localparam int SEQ_BIT = 60;
endpackage

// [rtl/cache_tlb_boot_init.sv]
// Purpose: Boot-time behaviour of tag RAM, replacement, TLB and L1 caches
// Assumes: Inputs synchronous to clock_in; one request of each kind per cycle
// Notes: Cache arrays are not cleared by reset; boot software invalidates them
`timescale 1ns/100ps
`default_nettype none
module cache_tlb_boot_init (
	// Clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// Tag RAM writes
	input wire logic tag_addr_wr_in,
	input wire logic tag_state_wr_in,
	input wire logic [1:0] tag_set_in,
	input wire logic [cache_tlb_pkg::ACC_HI:0] tag_acc_addr_in,
	input wire logic [cache_tlb_pkg::TAG_LO_W-1:0] tag_wr_data_in,
	// Replacement choice
	input wire logic alloc_req_in,
	input wire logic alloc_noncache_in,
	input wire logic [cache_tlb_pkg::SETS-1:0] set_allow_in,
	input wire logic force_set_three_in,
	output logic alloc_valid_out,
	output logic [1:0] alloc_set_out,
	// TLB
	input wire logic tlb_entry_write_op_in,
	input wire logic [1:0] tlb_set_in,
	input wire logic [cache_tlb_pkg::TLB_IDX_W-1:0] tlb_index_in,
	input wire logic [cache_tlb_pkg::VPN_W-1:0] tlb_high_half_reg_in,
	input wire logic [cache_tlb_pkg::LO_W-1:0] tlb_low_half_reg_in,
	input wire logic tlb_lookup_in,
	input wire logic [cache_tlb_pkg::VPN_W-1:0] virtual_page_number_in,
	output logic tlb_hit_out,
	output logic [cache_tlb_pkg::LO_W-1:0] tlb_low_out,
	output logic tlb_multi_irq_out,
	// Instruction fetch
	input wire logic fetch_req_in,
	input wire logic [63:0] fetch_vaddr_in,
	output logic fetch_hit_out,
	output logic fetch_gather_out,
	output logic ext_fetch_req_out,
	output logic [63:0] ext_fetch_addr_out,
	// Data valid store and uncached loads
	input wire logic dcv_wr_in,
	input wire logic [cache_tlb_pkg::HALF_IDX_W-1:0] dcv_index_in,
	input wire logic [cache_tlb_pkg::WORDS-1:0] dcv_data_in,
	input wire logic ld_req_in,
	input wire logic [cache_tlb_pkg::PA_W-1:0] ld_addr_in,
	input wire logic [31:0] ld_rom_data_in,
	output logic ld_valid_out,
	output logic [31:0] ld_data_out,
	output logic ld_from_cache_out,
	output logic sc_corrupt_out,
	output logic [cache_tlb_pkg::TI_W-1:0] sc_corrupt_index_out
);
	localparam int NTI = 2 ** cache_tlb_pkg::TI_W;
	localparam int NTLB = 2 ** cache_tlb_pkg::TLB_IDX_W;
	localparam int NLINE = 2 ** cache_tlb_pkg::LINE_IDX_W;
	localparam int NHALF = 2 ** cache_tlb_pkg::HALF_IDX_W;
	localparam int SW = cache_tlb_pkg::SECT * cache_tlb_pkg::SECT_W;

	// ****************************************
	// Arrays
	// ****************************************
	logic [cache_tlb_pkg::TAG_W-1:0] tag_mem [cache_tlb_pkg::SETS][NTI];
	logic [SW-1:0] st_mem [cache_tlb_pkg::SETS][NTI];
	logic [cache_tlb_pkg::VPN_W-1:0] tlb_virtual_tag_array_mem [cache_tlb_pkg::TLB_SETS][NTLB];
	logic [cache_tlb_pkg::LO_W-1:0] tlb_physical_tag_array_mem [cache_tlb_pkg::TLB_SETS][NTLB];
	logic [cache_tlb_pkg::CTAG_W-1:0] ic_tag [NLINE];
	logic ic_vld [NLINE];
	logic [cache_tlb_pkg::CTAG_W-1:0] dc_tag [NLINE];
	logic [cache_tlb_pkg::WORDS-1:0] dc_vld [NHALF];
	logic [31:0] dc_data [NHALF * cache_tlb_pkg::WORDS];

	// First allowed set at or after start, round robin
	function automatic logic [2:0] pick_set(input logic [3:0] allow, input logic [1:0] start);
		logic [2:0] r;
		logic [1:0] s;
		r = 3'h0;
		for (int k = cache_tlb_pkg::SETS - 1; k >= 0; k--) begin
			s = start + 2'(k);
			if (allow[s]) begin
				r = {1'b1, s};
			end
		end
		return r;
	endfunction

	// ****************************************
	// Tag RAM writes
	// ****************************************
	logic [cache_tlb_pkg::TI_W-1:0] tw_idx;
	logic [SW-1:0] st_new;
	logic [cache_tlb_pkg::TAG_W-1:0] tag_new;
	always_comb begin
		tw_idx = tag_acc_addr_in[cache_tlb_pkg::TI_LO +: cache_tlb_pkg::TI_W];
		tag_new = {tag_acc_addr_in[cache_tlb_pkg::ACC_HI:cache_tlb_pkg::ACC_LO],
			tag_wr_data_in};
		st_new = st_mem[tag_set_in][tw_idx];
		for (int s = 0; s < cache_tlb_pkg::SECT; s++) begin
			if (tag_wr_data_in[cache_tlb_pkg::WEN_LO + s]) begin
				st_new[s*cache_tlb_pkg::SECT_W +: cache_tlb_pkg::SECT_W] =
					tag_wr_data_in[s*cache_tlb_pkg::SECT_W +: cache_tlb_pkg::SECT_W];
			end
		end
	end
	always_ff @(posedge clock_in) begin
		if (tag_addr_wr_in) begin
			tag_mem[tag_set_in][tw_idx] <= tag_new;
		end
		if (tag_state_wr_in) begin
			st_mem[tag_set_in][tw_idx] <= st_new;
		end
	end

	// ****************************************
	// Replacement choice
	// ****************************************
	logic [1:0] rr_q, rr_d;
	logic alloc_valid_d;
	logic [1:0] alloc_set_d;
	logic [2:0] pick;
	always_comb begin
		pick = pick_set(set_allow_in, rr_q);
		rr_d = rr_q;
		alloc_valid_d = 1'b0;
		alloc_set_d = alloc_set_out;
		if (alloc_req_in) begin
			alloc_valid_d = 1'b1;
			if (force_set_three_in) begin
				alloc_set_d = 2'h3;
			end else if (alloc_noncache_in) begin
				alloc_set_d = 2'h0;
			end else begin
				alloc_valid_d = pick[2];
				alloc_set_d = pick[1:0];
				rr_d = pick[2] ? pick[1:0] + 2'h1 : rr_q;
			end
		end
	end
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			rr_q <= 2'h0;
			alloc_valid_out <= 1'b0;
			alloc_set_out <= 2'h0;
		end else begin
			rr_q <= rr_d;
			alloc_valid_out <= alloc_valid_d;
			alloc_set_out <= alloc_set_d;
		end
	end

	// ****************************************
	// TLB
	// ****************************************
	logic [cache_tlb_pkg::TLB_IDX_W-1:0] tl_idx;
	logic [1:0] n_match;
	logic [cache_tlb_pkg::LO_W-1:0] lo_sel;
	logic hit_d, multi_d;
	always_comb begin
		tl_idx = virtual_page_number_in[cache_tlb_pkg::TLB_IDX_W-1:0];
		n_match = 2'h0;
		lo_sel = '0;
		for (int s = 0; s < cache_tlb_pkg::TLB_SETS; s++) begin
			if (tlb_virtual_tag_array_mem[s][tl_idx] == virtual_page_number_in) begin
				n_match = n_match + 2'h1;
				lo_sel = tlb_physical_tag_array_mem[s][tl_idx];
			end
		end
		multi_d = tlb_lookup_in && (n_match > 2'h1);
		hit_d = tlb_lookup_in && (n_match == 2'h1) && lo_sel[cache_tlb_pkg::LO_VALID];
	end
	always_ff @(posedge clock_in) begin
		if (tlb_entry_write_op_in) begin
			tlb_virtual_tag_array_mem[tlb_set_in][tlb_index_in] <= tlb_high_half_reg_in;
			tlb_physical_tag_array_mem[tlb_set_in][tlb_index_in] <= tlb_low_half_reg_in;
		end
		if (reset_in) begin
			tlb_hit_out <= 1'b0;
			tlb_low_out <= '0;
			tlb_multi_irq_out <= 1'b0;
		end else begin
			tlb_hit_out <= hit_d;
			tlb_low_out <= hit_d ? lo_sel : tlb_low_out;
			tlb_multi_irq_out <= multi_d;
		end
	end

	// ****************************************
	// Instruction fetch, 16 KByte direct mapped
	// ****************************************
	logic [4:0] attr;
	logic [cache_tlb_pkg::LINE_IDX_W-1:0] if_idx;
	logic [cache_tlb_pkg::CTAG_W-1:0] if_tag;
	logic ic_hit, ic_we, ic_we_vld;
	logic fhit_d, fgat_d, ext_d;
	logic [63:0] ext_addr_d;
	always_comb begin
		attr = fetch_vaddr_in[63:cache_tlb_pkg::ATTR_LO];
		if_idx = fetch_vaddr_in[cache_tlb_pkg::LINE_LO +: cache_tlb_pkg::LINE_IDX_W];
		if_tag = fetch_vaddr_in[cache_tlb_pkg::CTAG_LO +: cache_tlb_pkg::CTAG_W];
		ic_hit = ic_vld[if_idx] && (ic_tag[if_idx] == if_tag);
		ic_we = 1'b0;
		ic_we_vld = 1'b0;
		fhit_d = 1'b0;
		fgat_d = 1'b0;
		ext_d = 1'b0;
		ext_addr_d = ext_fetch_addr_out;
		if (fetch_req_in) begin
			case (attr)
				cache_tlb_pkg::ATTR_GATHER: begin
					fgat_d = 1'b1;
					if (ic_hit) begin
						fhit_d = 1'b1;
					end else begin
						ext_d = 1'b1;
						ext_addr_d = fetch_vaddr_in;
						ext_addr_d[cache_tlb_pkg::SEQ_BIT] = 1'b1;
						ic_we = 1'b1;
						ic_we_vld = 1'b1;
					end
				end
				cache_tlb_pkg::ATTR_UNC_SEQ: begin
					ext_d = 1'b1;
					ext_addr_d = fetch_vaddr_in;
					ic_we = 1'b1;
				end
				default: begin
					ext_d = 1'b0;
				end
			endcase
		end
	end
	always_ff @(posedge clock_in) begin
		if (ic_we) begin
			ic_tag[if_idx] <= if_tag;
			ic_vld[if_idx] <= ic_we_vld;
		end
		if (reset_in) begin
			fetch_hit_out <= 1'b0;
			fetch_gather_out <= 1'b0;
			ext_fetch_req_out <= 1'b0;
			ext_fetch_addr_out <= '0;
		end else begin
			fetch_hit_out <= fhit_d;
			fetch_gather_out <= fgat_d;
			ext_fetch_req_out <= ext_d;
			ext_fetch_addr_out <= ext_addr_d;
		end
	end

	// ****************************************
	// Uncached loads through the data cache
	// ****************************************
	logic [cache_tlb_pkg::LINE_IDX_W-1:0] ld_line;
	logic [cache_tlb_pkg::HALF_IDX_W-1:0] ld_half;
	logic [1:0] ld_word;
	logic [cache_tlb_pkg::CTAG_W-1:0] ld_tag;
	logic [cache_tlb_pkg::TI_W-1:0] ts_idx;
	logic [1:0] ts_set;
	logic stale_hit, is_tag_ld, dc_fill;
	logic [cache_tlb_pkg::WORDS-1:0] vld_new;
	logic [31:0] ld_d;
	always_comb begin
		ld_line = ld_addr_in[cache_tlb_pkg::LINE_LO +: cache_tlb_pkg::LINE_IDX_W];
		ld_half = ld_addr_in[cache_tlb_pkg::HALF_LO +: cache_tlb_pkg::HALF_IDX_W];
		ld_word = ld_addr_in[cache_tlb_pkg::WORD_LO +: 2];
		ld_tag = ld_addr_in[cache_tlb_pkg::CTAG_LO +: cache_tlb_pkg::CTAG_W];
		ts_idx = ld_addr_in[cache_tlb_pkg::TI_LO +: cache_tlb_pkg::TI_W];
		ts_set = ld_addr_in[cache_tlb_pkg::TS_SET_LO +: 2];
		is_tag_ld = ld_addr_in[cache_tlb_pkg::PA_W-1:cache_tlb_pkg::TS_PAGE_LO]
			== cache_tlb_pkg::TAG_SPACE_PAGE;
		stale_hit = dc_vld[ld_half][ld_word] && (dc_tag[ld_line] == ld_tag);
		dc_fill = 1'b0;
		vld_new = dc_vld[ld_half];
		ld_d = ld_rom_data_in;
		if (ld_req_in) begin
			if (is_tag_ld) begin
				ld_d = ld_addr_in[cache_tlb_pkg::TS_STATE_BIT] ?
					32'(st_mem[ts_set][ts_idx]) : 32'(tag_mem[ts_set][ts_idx]);
			end else if (stale_hit) begin
				ld_d = dc_data[{ld_half, ld_word}];
			end else begin
				dc_fill = 1'b1;
				vld_new[ld_word] = 1'b0;
			end
		end
	end
	always_ff @(posedge clock_in) begin
		if (dcv_wr_in) begin
			dc_vld[dcv_index_in] <= dcv_data_in;
		end else if (dc_fill) begin
			dc_vld[ld_half] <= vld_new;
		end
		if (dc_fill) begin
			dc_tag[ld_line] <= ld_tag;
			dc_data[{ld_half, ld_word}] <= ld_rom_data_in;
		end
		if (reset_in) begin
			ld_valid_out <= 1'b0;
			ld_data_out <= '0;
			ld_from_cache_out <= 1'b0;
			sc_corrupt_out <= 1'b0;
			sc_corrupt_index_out <= '0;
		end else begin
			ld_valid_out <= ld_req_in;
			ld_data_out <= ld_req_in ? ld_d : ld_data_out;
			ld_from_cache_out <= ld_req_in && !is_tag_ld && stale_hit;
			sc_corrupt_out <= ld_req_in && is_tag_ld;
			sc_corrupt_index_out <= (ld_req_in && is_tag_ld) ? ts_idx
				: sc_corrupt_index_out;
		end
	end
endmodule
`default_nettype wire

// [verif/boot_init_sva.sv]
// Purpose: Port assertions for cache_tlb_boot_init
// Assumes: Sees only the top ports
// Notes: Bind follows the module
`timescale 1ns/100ps
`default_nettype none
module boot_init_sva (
	// Clock and requests
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic alloc_req_in,
	input wire logic alloc_noncache_in,
	input wire logic [3:0] set_allow_in,
	input wire logic force_set_three_in,
	input wire logic tlb_lookup_in,
	input wire logic fetch_req_in,
	input wire logic [63:0] fetch_vaddr_in,
	input wire logic ld_req_in,
	input wire logic [39:0] ld_addr_in,
	// Answers
	input wire logic alloc_valid_out,
	input wire logic [1:0] alloc_set_out,
	input wire logic tlb_hit_out,
	input wire logic tlb_multi_irq_out,
	input wire logic fetch_hit_out,
	input wire logic fetch_gather_out,
	input wire logic ext_fetch_req_out,
	input wire logic [63:0] ext_fetch_addr_out,
	input wire logic ld_valid_out,
	input wire logic ld_from_cache_out,
	input wire logic sc_corrupt_out,
	input wire logic [3:0] sc_corrupt_index_out
);
	logic [3:0] allow_q;
	logic [4:0] attr;
	assign attr = fetch_vaddr_in[63:59];
	always_ff @(posedge clock_in) allow_q <= set_allow_in;
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	a_force_three_set: assert property (alloc_req_in && force_set_three_in |=>
		alloc_valid_out && alloc_set_out == 2'h3) else $error("force set");
	a_noncache_set_zero: assert property (alloc_req_in && !force_set_three_in &&
		alloc_noncache_in |=> alloc_valid_out && alloc_set_out == 2'h0) else $error("uncached set");
	a_allowed_set_only: assert property (alloc_req_in && !force_set_three_in &&
		!alloc_noncache_in |=> alloc_valid_out == (allow_q != 4'h0) &&
		(!alloc_valid_out || allow_q[alloc_set_out])) else $error("set allow");
	a_multi_irq_lookup: assert property (tlb_multi_irq_out |->
		!tlb_hit_out && $past(tlb_lookup_in)) else $error("multi match");
	a_gather_fetch: assert property (fetch_req_in && attr == cache_tlb_pkg::ATTR_GATHER |=>
		fetch_gather_out && fetch_hit_out != ext_fetch_req_out) else $error("gather");
	a_miss_bit_sixty: assert property (fetch_req_in && attr == cache_tlb_pkg::ATTR_GATHER |=>
		!ext_fetch_req_out || ext_fetch_addr_out == ($past(fetch_vaddr_in) |
		64'h1000_0000_0000_0000)) else $error("bit sixty");
	a_seq_fetch_addr: assert property (fetch_req_in && attr == cache_tlb_pkg::ATTR_UNC_SEQ |=>
		ext_fetch_req_out && !fetch_gather_out && ext_fetch_addr_out == $past(fetch_vaddr_in))
		else $error("sequential");
	a_other_attr_quiet: assert property (fetch_req_in && attr != cache_tlb_pkg::ATTR_GATHER &&
		attr != cache_tlb_pkg::ATTR_UNC_SEQ |=> !ext_fetch_req_out && !fetch_gather_out)
		else $error("other attr");
	a_load_answer: assert property (ld_req_in |=> ld_valid_out) else $error("load");
	a_tag_load_corrupt: assert property (ld_req_in && ld_addr_in[39:24] ==
		cache_tlb_pkg::TAG_SPACE_PAGE |=> sc_corrupt_out &&
		sc_corrupt_index_out == $past(ld_addr_in[10:7])) else $error("corrupt");
	cover property (tlb_multi_irq_out);
	cover property (ld_from_cache_out);
	cover property (fetch_hit_out);
endmodule
bind cache_tlb_boot_init boot_init_sva u_boot_init_sva (.clock_in, .reset_in, .alloc_req_in,
	.alloc_noncache_in, .set_allow_in, .force_set_three_in, .tlb_lookup_in, .fetch_req_in,
	.fetch_vaddr_in, .ld_req_in, .ld_addr_in, .alloc_valid_out, .alloc_set_out, .tlb_hit_out,
	.tlb_multi_irq_out, .fetch_hit_out, .fetch_gather_out, .ext_fetch_req_out,
	.ext_fetch_addr_out, .ld_valid_out, .ld_from_cache_out, .sc_corrupt_out, .sc_corrupt_index_out);
`default_nettype wire

// [verif/boot_rom_model.sv]
// Purpose: Boot ROM seen by uncached loads
// Assumes: Combinational read
// Notes: Contents shift with gen_in so stale hits show
`timescale 1ns/100ps
`default_nettype none
module boot_rom_model (
	// Address and contents
	input wire logic [39:0] addr_in,
	input wire logic [7:0] gen_in,
	// Read data
	output logic [31:0] data_out
);
	assign data_out = {gen_in, addr_in[23:0]};
endmodule
`default_nettype wire

// [verif/cache_tlb_boot_init_tb.sv]
// Purpose: Self-checking bench for cache_tlb_boot_init
// Assumes: Inputs change at the falling edge
// Notes: Arrays start unknown, so scenarios invalidate first
`timescale 1ns/100ps
`default_nettype none
module cache_tlb_boot_init_tb;
	logic clock_in, reset_in, tag_addr_wr_in, tag_state_wr_in, alloc_req_in, alloc_noncache_in;
	logic force_set_three_in, tlb_entry_write_op_in, tlb_lookup_in, fetch_req_in, dcv_wr_in;
	logic ld_req_in, alloc_valid_out, tlb_hit_out, tlb_multi_irq_out, fetch_hit_out;
	logic fetch_gather_out, ext_fetch_req_out, ld_valid_out, ld_from_cache_out, sc_corrupt_out;
	logic [1:0] tag_set_in, tlb_set_in, alloc_set_out;
	logic [21:0] tag_acc_addr_in;
	logic [19:0] tag_wr_data_in, tlb_high_half_reg_in, virtual_page_number_in;
	logic [3:0] set_allow_in, tlb_index_in, dcv_data_in, sc_corrupt_index_out;
	logic [31:0] tlb_low_half_reg_in, ld_rom_data_in, tlb_low_out, ld_data_out;
	logic [63:0] fetch_vaddr_in, ext_fetch_addr_out;
	logic [9:0] dcv_index_in;
	logic [39:0] ld_addr_in;
	logic [7:0] rom_gen;
	int n_mismatch, checks_done;
	cache_tlb_boot_init u_cache_tlb_boot_init (.clock_in, .reset_in, .tag_addr_wr_in,
		.tag_state_wr_in, .tag_set_in, .tag_acc_addr_in, .tag_wr_data_in, .alloc_req_in,
		.alloc_noncache_in, .set_allow_in, .force_set_three_in, .alloc_valid_out, .alloc_set_out,
		.tlb_entry_write_op_in, .tlb_set_in, .tlb_index_in, .tlb_high_half_reg_in,
		.tlb_low_half_reg_in, .tlb_lookup_in, .virtual_page_number_in, .tlb_hit_out, .tlb_low_out,
		.tlb_multi_irq_out, .fetch_req_in, .fetch_vaddr_in, .fetch_hit_out, .fetch_gather_out,
		.ext_fetch_req_out, .ext_fetch_addr_out, .dcv_wr_in, .dcv_index_in, .dcv_data_in,
		.ld_req_in, .ld_addr_in, .ld_rom_data_in, .ld_valid_out, .ld_data_out,
		.ld_from_cache_out, .sc_corrupt_out, .sc_corrupt_index_out);
	boot_rom_model u_boot_rom_model (.addr_in(ld_addr_in), .gen_in(rom_gen),
		.data_out(ld_rom_data_in));
	// ********
	// Tasks
	// ********
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic alloc(input logic f, n, input logic [3:0] al, input logic v, input logic [1:0] s);
		alloc_req_in = 1'b1;
		force_set_three_in = f;
		alloc_noncache_in = n;
		set_allow_in = al;
		@(negedge clock_in);
		alloc_req_in = 1'b0;
		chk(alloc_valid_out, v);
		if (v) chk(alloc_set_out, s);
		@(negedge clock_in);
	endtask
	task automatic tlb_entry_write_op(input logic [1:0] s, input logic [3:0] i, input logic [19:0] hi,
		input logic [31:0] lo);
		tlb_entry_write_op_in = 1'b1;
		tlb_set_in = s;
		tlb_index_in = i;
		tlb_high_half_reg_in = hi;
		tlb_low_half_reg_in = lo;
		@(negedge clock_in);
		tlb_entry_write_op_in = 1'b0;
		@(negedge clock_in);
	endtask
	task automatic look(input logic [19:0] virtual_page_number, input logic h, m, input logic [31:0] lo);
		tlb_lookup_in = 1'b1;
		virtual_page_number_in = virtual_page_number;
		@(negedge clock_in);
		tlb_lookup_in = 1'b0;
		chk({tlb_hit_out, tlb_multi_irq_out}, {h, m});
		if (h) chk(tlb_low_out, lo);
		@(negedge clock_in);
	endtask
	task automatic fetch(input logic [63:0] a, input logic h, g, e, input logic [63:0] ea);
		fetch_req_in = 1'b1;
		fetch_vaddr_in = a;
		@(negedge clock_in);
		fetch_req_in = 1'b0;
		chk({fetch_hit_out, fetch_gather_out, ext_fetch_req_out}, {h, g, e});
		if (e) chk(ext_fetch_addr_out, ea);
		@(negedge clock_in);
	endtask
	task automatic dcv(input logic [3:0] d);
		dcv_wr_in = 1'b1;
		dcv_index_in = 10'h123;
		dcv_data_in = d;
		@(negedge clock_in);
		dcv_wr_in = 1'b0;
		@(negedge clock_in);
	endtask
	task automatic load(input logic [39:0] a, input logic [7:0] g, input logic [31:0] d,
		input logic fc, c);
		rom_gen = g;
		ld_req_in = 1'b1;
		ld_addr_in = a;
		@(negedge clock_in);
		ld_req_in = 1'b0;
		chk({ld_valid_out, ld_from_cache_out, sc_corrupt_out}, {1'b1, fc, c});
		chk(ld_data_out, d);
		@(negedge clock_in);
	endtask
	// ********
	// Scenarios
	// ********
	task automatic t_alloc();
		alloc(1'b1, 1'b0, 4'hF, 1'b1, 2'h3);
		alloc(1'b0, 1'b1, 4'hF, 1'b1, 2'h0);
		alloc(1'b0, 1'b0, 4'h4, 1'b1, 2'h2);
		alloc(1'b0, 1'b0, 4'h0, 1'b0, 2'h0);
		alloc(1'b0, 1'b0, 4'hD, 1'b1, 2'h3);
		alloc(1'b0, 1'b0, 4'hD, 1'b1, 2'h0);
		alloc(1'b0, 1'b0, 4'hD, 1'b1, 2'h2);
	endtask
	task automatic t_tlb();
		for (int i = 0; i < 16; i++) begin
			for (int s = 0; s < 3; s++) begin
				tlb_entry_write_op(2'(s), 4'(i), 20'(s), 32'h0);
			end
		end
		look(20'h0_0000, 1'b0, 1'b0, 32'h0);
		tlb_entry_write_op(2'h1, 4'h5, 20'h0_0005, 32'h0000_ABC1);
		look(20'h0_0005, 1'b1, 1'b0, 32'h0000_ABC1);
		tlb_entry_write_op(2'h2, 4'h5, 20'h0_0005, 32'h0000_0DE1);
		look(20'h0_0005, 1'b0, 1'b1, 32'h0);
	endtask
	task automatic t_fetch();
		fetch(64'h9000_0000_0000_1240, 1'b0, 1'b0, 1'b1, 64'h9000_0000_0000_1240);
		fetch(64'h8000_0000_0000_1240, 1'b0, 1'b1, 1'b1, 64'h9000_0000_0000_1240);
		fetch(64'h8000_0000_0000_1240, 1'b1, 1'b1, 1'b0, 64'h0);
		fetch(64'h8000_0000_0000_5240, 1'b0, 1'b1, 1'b1, 64'h9000_0000_0000_5240);
		fetch(64'h8000_0000_0000_1240, 1'b0, 1'b1, 1'b1, 64'h9000_0000_0000_1240);
		fetch(64'hA000_0000_0000_1240, 1'b0, 1'b0, 1'b0, 64'h0);
	endtask
	task automatic t_load();
		dcv(4'h0);
		load(40'h00_0000_1238, 8'h11, 32'h1100_1238, 1'b0, 1'b0);
		load(40'h00_0000_1238, 8'h22, 32'h2200_1238, 1'b0, 1'b0);
		dcv(4'hF);
		load(40'h00_0000_1238, 8'h33, 32'h2200_1238, 1'b1, 1'b0);
		dcv(4'h0);
		load(40'h00_0000_1238, 8'h44, 32'h4400_1238, 1'b0, 1'b0);
		tag_addr_wr_in = 1'b1;
		tag_set_in = 2'h3;
		tag_acc_addr_in = 22'h30_0280;
		tag_wr_data_in = 20'h0_41FC;
		@(negedge clock_in);
		tag_addr_wr_in = 1'b0;
		tag_state_wr_in = 1'b1;
		tag_wr_data_in = 20'h0_FB6D;
		@(negedge clock_in);
		tag_wr_data_in = 20'h0_2010;
		@(negedge clock_in);
		tag_state_wr_in = 1'b0;
		load(40'h00_18E0_0280, 8'h44, 32'h0000_0B55, 1'b0, 1'b1);
		chk(sc_corrupt_index_out, 64'h5);
		load(40'h00_1860_0280, 8'h44, 32'h0030_41FC, 1'b0, 1'b1);
	endtask
	// ********
	// Run
	// ********
	initial begin
		clock_in = 1'b0;
		forever #5 clock_in = ~clock_in;
	end
	initial begin
		repeat (3000) @(posedge clock_in);
		n_mismatch++;
		end_of_test();
	end
	initial begin
		reset_in = 1'b1;
		{tag_addr_wr_in, tag_state_wr_in, alloc_req_in, alloc_noncache_in, force_set_three_in} = '0;
		{tlb_entry_write_op_in, tlb_lookup_in, fetch_req_in, dcv_wr_in, ld_req_in} = '0;
		{tag_set_in, tag_acc_addr_in, tag_wr_data_in, set_allow_in, tlb_set_in, tlb_index_in} = '0;
		{tlb_high_half_reg_in, tlb_low_half_reg_in, virtual_page_number_in, fetch_vaddr_in} = '0;
		{dcv_index_in, dcv_data_in, ld_addr_in, rom_gen} = '0;
		repeat (6) @(negedge clock_in);
		reset_in = 1'b0;
		chk({alloc_valid_out, tlb_hit_out, fetch_gather_out, ext_fetch_req_out, ld_valid_out}, 64'h0);
		t_alloc();
		t_tlb();
		t_fetch();
		t_load();
		end_of_test();
	end
endmodule
`default_nettype wire
